//--- common/vac_defines.vh
// Register offsets, field positions, reset values and constants of the alarm block
`ifndef VAC_DEFINES_VH
`define VAC_DEFINES_VH

`define VAC_OFS_BAND_LOW 7'h20
`define VAC_OFS_BAND_HIGH 7'h22
`define VAC_OFS_X_L1 7'h24
`define VAC_OFS_Y_L1 7'h26
`define VAC_OFS_Z_L1 7'h28
`define VAC_OFS_X_L2 7'h2a
`define VAC_OFS_Y_L2 7'h2c
`define VAC_OFS_Z_L2 7'h2e
`define VAC_OFS_SELECTOR 7'h30
`define VAC_OFS_SYS_LIMIT 7'h32
`define VAC_OFS_ALARM_CFG 7'h34
`define VAC_OFS_PIN_POL 7'h36
`define VAC_OFS_DIAG 7'h3c

`define VAC_RST_ZERO 16'h0000
`define VAC_RST_ALARM_CFG 16'h0080
`define VAC_RST_PIN_POL 16'h007b

`define VAC_SEL_RATE_HI 9
`define VAC_SEL_RATE_LO 8
`define VAC_SEL_BAND_HI 2
`define VAC_SEL_BAND_LO 0

`define VAC_CFG_NO_AUTOCLR 12
`define VAC_CFG_DELAY_HI 11
`define VAC_CFG_DELAY_LO 8
`define VAC_CFG_LATCH 7
`define VAC_CFG_PIN_EN 6
`define VAC_CFG_SYS_POL 5
`define VAC_CFG_SYS_TEMP 4
`define VAC_CFG_SYS_EN 3

`define VAC_POL_ALARM2 1
`define VAC_POL_ALARM1 0

`define VAC_DIAG_SYS 14
`define VAC_DIAG_A2_LO 11
`define VAC_DIAG_A1_LO 8

`define VAC_GCMD_CLEAR 4

`define VAC_BIN_W 12
`define VAC_NUM_BANDS 6
`define VAC_NUM_RATES 4

`endif

//--- rtl/vac_alarm_config.v
// Alarm configuration registers, per-band alarm store and alarm evaluation
//
// Overview of operation
// - Spectrum modes: z level-2 limit is the Alarm 2 threshold of selected alarm.
// - Time-capture mode: z level-2 compares z statistic, or root-sum-square if enabled.
// - Selector: rate in bits 9:8, band in bits 2:0, other bits ignored.
// - Six alarms per each of four rate settings, bands one to six.
// - Rate field 00,01,10,11 decode to rate settings zero through three.
// - Selector write loads stored band and limit attributes into readable registers.
// - Band and limit register writes update the alarm the selector points at.
// - System limit holds the temperature or supply alarm threshold.
// - Config bit 4: one compares temperature, zero compares supply.
// - Status read clears latched spectral flags unless config bit 12 is set.
// - Config bits 11:8 give records required before a band flag sets.
// - Config bit 7 latches flags until global clear command bit 4.
// - Config bit 6 drives alarm 1 and alarm 2 onto their pins.
// - Config bit 5: one alarms below the limit, zero above it.
// - Config bit 3 enables the system alarm.
// - Config bits 2,1,0 enable z, y, x axis evaluation.
// - Polarity bits 1,0 set second and first pin level: one active high.
// - Low and high bin registers hold the band bounds in bits 11:0.
// - Status bit 14 reports the system alarm.
// - Status bits 13:11 alarm 2 z,y,x; bits 10:8 alarm 1 z,y,x.
`timescale 1ns/100ps
`default_nettype none
`include "vac_defines.vh"

module vac_alarm_config #(
    parameter MAG_W = 16,
    parameter BIN_W = `VAC_BIN_W
) (
    input wire mclk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_rd,
    input wire [6:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire global_clear,
    input wire manual_spectrum_mode,
    input wire automatic_spectrum_mode,
    input wire manual_time_capture_mode,
    input wire root_sum_square,
    input wire [1:0] active_rate,
    input wire bin_valid,
    input wire [BIN_W-1:0] bin_index,
    input wire [3*MAG_W-1:0] bin_mag,
    input wire record_end,
    input wire stat_valid,
    input wire [MAG_W-1:0] z_statistic,
    input wire [MAG_W-1:0] rss_statistic,
    input wire [15:0] temperature,
    input wire [15:0] supply,
    output wire [15:0] diagnostic_flags,
    output reg first_alarm_pin,
    output reg second_alarm_pin
);
    localparam NUM_ALARMS = `VAC_NUM_RATES * `VAC_NUM_BANDS;
    localparam ST_IDLE = 2'b01;
    localparam ST_LOAD = 2'b10;

    // Attribute store: one word each of low, high, and six limits per alarm
    reg [BIN_W-1:0] low_mem [0:NUM_ALARMS-1];
    reg [BIN_W-1:0] high_mem [0:NUM_ALARMS-1];
    reg [MAG_W-1:0] l1_mem [0:3*NUM_ALARMS-1];
    reg [MAG_W-1:0] l2_mem [0:3*NUM_ALARMS-1];

    reg [15:0] alarm_selector;
    reg [15:0] system_alarm_limit;
    reg [15:0] alarm_configuration;
    reg [15:0] alarm_pin_polarity;
    reg [BIN_W-1:0] band_low_bin;
    reg [BIN_W-1:0] band_high_bin;
    reg [3*MAG_W-1:0] level1_limit;
    reg [3*MAG_W-1:0] level2_limit;
    reg [1:0] state;
    reg [6:0] spectral_flags;
    reg [2:0] met1_d;
    reg [2:0] met2_d;
    reg time_met;
    reg sys_met;

    wire [4:0] sel_index;
    wire sel_valid;
    wire spectrum_mode;
    wire [2:0] axis_en;
    wire [2:0] met1;
    wire [2:0] met2;
    wire [15:0] sys_value;
    wire sys_cond;
    wire [MAG_W-1:0] time_value;
    wire status_read;
    wire clear_now;
    wire [6:0] spectral_set;

    // Maps rate setting and band 1..6 onto a flat index; band 0 and 7 are invalid
    function [4:0] alarm_index;
        input [1:0] rate;
        input [2:0] band;
        begin
            alarm_index = {rate, 3'b000} - {2'b00, rate, 1'b0} + {2'b00, band} - 5'd1;
        end
    endfunction

    function band_ok;
        input [2:0] band;
        begin
            band_ok = (band != 3'd0) && (band != 3'd7);
        end
    endfunction

    // Rate bits decode directly as the setting number
    assign sel_index = alarm_index(alarm_selector[`VAC_SEL_RATE_HI:`VAC_SEL_RATE_LO],
        alarm_selector[`VAC_SEL_BAND_HI:`VAC_SEL_BAND_LO]);
    assign sel_valid = band_ok(alarm_selector[`VAC_SEL_BAND_HI:`VAC_SEL_BAND_LO]);
    assign spectrum_mode = manual_spectrum_mode || automatic_spectrum_mode;
    assign axis_en = alarm_configuration[2:0];
    assign status_read = reg_rd && (reg_addr == `VAC_OFS_DIAG);

    // Selector write: store it, then load the mirrors one cycle later
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (reg_wr && reg_addr == `VAC_OFS_SELECTOR)
                        state <= ST_LOAD;
                end
                ST_LOAD: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_selector <= `VAC_RST_ZERO;
            system_alarm_limit <= `VAC_RST_ZERO;
            alarm_configuration <= `VAC_RST_ALARM_CFG;
            alarm_pin_polarity <= `VAC_RST_PIN_POL;
            band_low_bin <= {BIN_W{1'b0}};
            band_high_bin <= {BIN_W{1'b0}};
            level1_limit <= {3*MAG_W{1'b0}};
            level2_limit <= {3*MAG_W{1'b0}};
        end else if (state == ST_LOAD) begin
            if (sel_valid) begin
                band_low_bin <= low_mem[sel_index];
                band_high_bin <= high_mem[sel_index];
                level1_limit <= {l1_mem[3*sel_index+2], l1_mem[3*sel_index+1],
                    l1_mem[3*sel_index]};
                level2_limit <= {l2_mem[3*sel_index+2], l2_mem[3*sel_index+1],
                    l2_mem[3*sel_index]};
            end
        end else if (reg_wr) begin
            if (reg_addr == `VAC_OFS_SELECTOR)
                alarm_selector <= reg_wdata;
            else if (reg_addr == `VAC_OFS_SYS_LIMIT)
                system_alarm_limit <= reg_wdata;
            else if (reg_addr == `VAC_OFS_ALARM_CFG)
                alarm_configuration <= reg_wdata;
            else if (reg_addr == `VAC_OFS_PIN_POL)
                alarm_pin_polarity <= reg_wdata;
            else if (reg_addr == `VAC_OFS_BAND_LOW)
                band_low_bin <= reg_wdata[BIN_W-1:0];
            else if (reg_addr == `VAC_OFS_BAND_HIGH)
                band_high_bin <= reg_wdata[BIN_W-1:0];
            else if (reg_addr == `VAC_OFS_X_L1)
                level1_limit[MAG_W-1:0] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L1)
                level1_limit[2*MAG_W-1:MAG_W] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Z_L1)
                level1_limit[3*MAG_W-1:2*MAG_W] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_X_L2)
                level2_limit[MAG_W-1:0] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L2)
                level2_limit[2*MAG_W-1:MAG_W] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Z_L2)
                level2_limit[3*MAG_W-1:2*MAG_W] <= reg_wdata[MAG_W-1:0];
        end
    end

    // Write-through into the store of the pointed alarm; no reset on memory
    always @(posedge mclk) begin
        if (reg_wr && state == ST_IDLE && sel_valid) begin
            if (reg_addr == `VAC_OFS_BAND_LOW)
                low_mem[sel_index] <= reg_wdata[BIN_W-1:0];
            else if (reg_addr == `VAC_OFS_BAND_HIGH)
                high_mem[sel_index] <= reg_wdata[BIN_W-1:0];
            else if (reg_addr == `VAC_OFS_X_L1)
                l1_mem[3*sel_index] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L1)
                l1_mem[3*sel_index+1] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Z_L1)
                l1_mem[3*sel_index+2] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_X_L2)
                l2_mem[3*sel_index] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L2)
                l2_mem[3*sel_index+1] <= reg_wdata[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Z_L2)
                l2_mem[3*sel_index+2] <= reg_wdata[MAG_W-1:0];
        end
    end

    // Live evaluation uses the mirrors, so only the selected alarm is checked
    genvar ax;
    generate
        for (ax = 0; ax < 3; ax = ax + 1) begin : g_axis
            vac_axis_eval #(.MAG_W(MAG_W), .BIN_W(BIN_W)) u_lvl1 (
                .mclk(mclk),
                .rst_n(rst_n),
                .enable(axis_en[ax] && spectrum_mode && sel_valid),
                .bin_valid(bin_valid),
                .bin_index(bin_index),
                .bin_mag(bin_mag[(ax+1)*MAG_W-1:ax*MAG_W]),
                .record_end(record_end),
                .low_bin(band_low_bin),
                .high_bin(band_high_bin),
                .threshold(level1_limit[(ax+1)*MAG_W-1:ax*MAG_W]),
                .delay(alarm_configuration[`VAC_CFG_DELAY_HI:`VAC_CFG_DELAY_LO]),
                .met(met1[ax])
            );
            // The z instance takes the z level-2 limit as its Alarm 2 threshold
            vac_axis_eval #(.MAG_W(MAG_W), .BIN_W(BIN_W)) u_lvl2 (
                .mclk(mclk),
                .rst_n(rst_n),
                .enable(axis_en[ax] && spectrum_mode && sel_valid),
                .bin_valid(bin_valid),
                .bin_index(bin_index),
                .bin_mag(bin_mag[(ax+1)*MAG_W-1:ax*MAG_W]),
                .record_end(record_end),
                .low_bin(band_low_bin),
                .high_bin(band_high_bin),
                .threshold(level2_limit[(ax+1)*MAG_W-1:ax*MAG_W]),
                .delay(alarm_configuration[`VAC_CFG_DELAY_HI:`VAC_CFG_DELAY_LO]),
                .met(met2[ax])
            );
        end
    endgenerate

    // Time-capture check of the z level-2 limit
    assign time_value = root_sum_square ? rss_statistic : z_statistic;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            time_met <= 1'b0;
        else if (!manual_time_capture_mode || !axis_en[2])
            time_met <= 1'b0;
        else if (stat_valid)
            time_met <= (time_value >= level2_limit[3*MAG_W-1:2*MAG_W]);
    end

    // System alarm: source, polarity, enable
    assign sys_value = alarm_configuration[`VAC_CFG_SYS_TEMP] ? temperature : supply;
    assign sys_cond = alarm_configuration[`VAC_CFG_SYS_POL] ?
        (sys_value < system_alarm_limit) : (sys_value > system_alarm_limit);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            sys_met <= 1'b0;
        else
            sys_met <= alarm_configuration[`VAC_CFG_SYS_EN] && sys_cond;
    end

    // Band flags set on the rising edge of each condition, capture and system flags on its level; set beats any clear
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            met1_d <= 3'b000;
            met2_d <= 3'b000;
        end else begin
            met1_d <= met1;
            met2_d <= met2;
        end
    end

    assign spectral_set = {sys_met, (met2 & ~met2_d) | {time_met, 2'b00}, met1 & ~met1_d};
    // Read auto-clear applies to latched spectral bits unless suppressed
    assign clear_now = global_clear ||
        (status_read && !alarm_configuration[`VAC_CFG_NO_AUTOCLR]);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            spectral_flags <= 7'h00;
        end else if (!alarm_configuration[`VAC_CFG_LATCH]) begin
            // Unlatched flags simply follow the live conditions
            spectral_flags <= {sys_met, met2 | {time_met, 2'b00}, met1};
        end else if (global_clear) begin
            spectral_flags <= spectral_set;
        end else if (clear_now) begin
            spectral_flags <= {spectral_flags[6], 6'h00} | spectral_set;
        end else begin
            spectral_flags <= spectral_flags | spectral_set;
        end
    end

    assign diagnostic_flags = {1'b0, spectral_flags, 8'h00};

    // Pin drive: asserted level chosen per pin
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            first_alarm_pin <= 1'b1;
            second_alarm_pin <= 1'b1;
        end else begin
            first_alarm_pin <= (alarm_configuration[`VAC_CFG_PIN_EN] && |spectral_flags[2:0]) ~^
                alarm_pin_polarity[`VAC_POL_ALARM1];
            second_alarm_pin <= (alarm_configuration[`VAC_CFG_PIN_EN] &&
                |spectral_flags[5:3]) ~^ alarm_pin_polarity[`VAC_POL_ALARM2];
        end
    end

    // Read data registered, one cycle after the strobe
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `VAC_OFS_SELECTOR)
                reg_rdata <= alarm_selector;
            else if (reg_addr == `VAC_OFS_SYS_LIMIT)
                reg_rdata <= system_alarm_limit;
            else if (reg_addr == `VAC_OFS_ALARM_CFG)
                reg_rdata <= alarm_configuration;
            else if (reg_addr == `VAC_OFS_PIN_POL)
                reg_rdata <= alarm_pin_polarity;
            else if (reg_addr == `VAC_OFS_BAND_LOW)
                reg_rdata <= {{(16-BIN_W){1'b0}}, band_low_bin};
            else if (reg_addr == `VAC_OFS_BAND_HIGH)
                reg_rdata <= {{(16-BIN_W){1'b0}}, band_high_bin};
            else if (reg_addr == `VAC_OFS_X_L1)
                reg_rdata <= level1_limit[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L1)
                reg_rdata <= level1_limit[2*MAG_W-1:MAG_W];
            else if (reg_addr == `VAC_OFS_Z_L1)
                reg_rdata <= level1_limit[3*MAG_W-1:2*MAG_W];
            else if (reg_addr == `VAC_OFS_X_L2)
                reg_rdata <= level2_limit[MAG_W-1:0];
            else if (reg_addr == `VAC_OFS_Y_L2)
                reg_rdata <= level2_limit[2*MAG_W-1:MAG_W];
            else if (reg_addr == `VAC_OFS_Z_L2)
                reg_rdata <= level2_limit[3*MAG_W-1:2*MAG_W];
            else if (reg_addr == `VAC_OFS_DIAG)
                reg_rdata <= diagnostic_flags;
            else
                reg_rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

//--- rtl/vac_axis_eval.v
// Per-axis band test over one spectral record and consecutive-record counting
`timescale 1ns/100ps
`default_nettype none
`include "vac_defines.vh"

module vac_axis_eval #(
    parameter MAG_W = 16,
    parameter BIN_W = 12
) (
    input wire mclk,
    input wire rst_n,
    input wire enable,
    input wire bin_valid,
    input wire [BIN_W-1:0] bin_index,
    input wire [MAG_W-1:0] bin_mag,
    input wire record_end,
    input wire [BIN_W-1:0] low_bin,
    input wire [BIN_W-1:0] high_bin,
    input wire [MAG_W-1:0] threshold,
    input wire [3:0] delay,
    output reg met
);
    reg hit;
    reg [3:0] run;
    wire in_band;
    wire bin_hit;
    wire record_hit;

    assign in_band = (bin_index >= low_bin) && (bin_index <= high_bin);
    assign bin_hit = bin_valid && in_band && (bin_mag >= threshold);
    assign record_hit = hit || bin_hit;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hit <= 1'b0;
            run <= 4'h0;
            met <= 1'b0;
        end else if (!enable) begin
            hit <= 1'b0;
            run <= 4'h0;
            met <= 1'b0;
        end else if (record_end) begin
            hit <= 1'b0;
            if (record_hit) begin
                // Counter saturates at 15, the largest delay setting
                if (run != 4'hf)
                    run <= run + 4'h1;
                // Delay 0 and 1 both flag on the first qualifying record
                met <= (({1'b0, run} + 5'h01) >= {1'b0, delay});
            end else begin
                run <= 4'h0;
                met <= 1'b0;
            end
        end else if (bin_hit) begin
            hit <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- sim/vac_alarm_config_asserts.sv
// Port-level concurrent checks of the alarm configuration block
`timescale 1ns/100ps
`default_nettype none
`include "vac_defines.vh"
module vac_alarm_config_asserts (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic global_clear,
    input wire logic record_end,
    input wire logic [15:0] temperature,
    input wire logic [15:0] supply,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] diagnostic_flags,
    input wire logic first_alarm_pin,
    input wire logic second_alarm_pin
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles since anything that may legally move the system flag
    logic [1:0] quiet;
    logic [15:0] temp_q;
    logic [15:0] sup_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            quiet <= 2'h0;
            temp_q <= 16'h0000;
            sup_q <= 16'h0000;
        end else begin
            temp_q <= temperature;
            sup_q <= supply;
            if (reg_wr || global_clear || temperature != temp_q || supply != sup_q) begin
                quiet <= 2'h0;
            end else if (quiet != 2'h3) begin
                quiet <= quiet + 2'h1;
            end
        end
    end
    a_unmapped_zero: assert property (reg_rd && reg_addr[6] |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_status_read: assert property (reg_rd && reg_addr == `VAC_OFS_DIAG
        |=> reg_rdata[14:8] == $past(diagnostic_flags[14:8]))
        else $error("status read differs from flags");
    a_spec_rise: assert property (|(diagnostic_flags[12:8] & ~$past(diagnostic_flags[12:8]))
        |-> $past(record_end) || $past(record_end, 2) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("spectral flag rose without a record");
    a_spec_stay: assert property ((!record_end && !reg_rd && !reg_wr && !global_clear) [*3]
        |=> $stable(diagnostic_flags[12:8]))
        else $error("spectral flags moved while idle");
    a_pin1_cause: assert property ($changed(first_alarm_pin) |-> !$past(rst_n, 3)
        || $past(reg_wr, 2) || $past(reg_wr, 3)
        || $past(diagnostic_flags[10:8]) != $past(diagnostic_flags[10:8], 3))
        else $error("first pin moved without cause");
    a_pin2_cause: assert property ($changed(second_alarm_pin) |-> !$past(rst_n, 3)
        || $past(reg_wr, 2) || $past(reg_wr, 3)
        || $past(diagnostic_flags[13:11]) != $past(diagnostic_flags[13:11], 3))
        else $error("second pin moved without cause");
    a_sys_steady: assert property (quiet == 2'h3 |-> $stable(diagnostic_flags[14]))
        else $error("system flag moved without cause");
    c_spec: cover property (|diagnostic_flags[13:8]);
    c_sys: cover property (diagnostic_flags[14]);
    c_pins: cover property (first_alarm_pin && second_alarm_pin);
endmodule
`default_nettype wire

//--- sim/vac_alarm_config_tb_top.sv
// Register-level tests of the alarm configuration block
`timescale 1ns/100ps
`default_nettype none
`include "vac_defines.vh"
module vac_alarm_config_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, first_alarm_pin, second_alarm_pin;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, diagnostic_flags, v;
    logic global_clear = 1'b0, manual_spectrum_mode = 1'b0, automatic_spectrum_mode = 1'b0;
    logic manual_time_capture_mode = 1'b0, root_sum_square = 1'b0, bin_valid = 1'b0;
    logic record_end = 1'b0, stat_valid = 1'b0;
    logic [1:0] active_rate = 2'h0;
    logic [11:0] bin_index = 12'h000;
    logic [47:0] bin_mag = 48'h0;
    logic [15:0] z_statistic = 16'h0100, rss_statistic = 16'h0300;
    logic [15:0] temperature = 16'h2000, supply = 16'h0800;
    int n_fail = 0, compares = 0;
    logic [6:0] ra [6] = '{7'h2e, 7'h30, 7'h32, 7'h34, 7'h36, 7'h40};
    logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0080, 16'h007b, 16'h0000};
    logic [15:0] cv [8] = '{16'h0010, 16'h0020, 16'h0100, 16'h0100, 16'h0100, 16'h8000,
        16'h8000, 16'h0200};
    logic [15:0] sc [5] = '{16'h0018, 16'h0038, 16'h0028, 16'h0008, 16'h0010};
    logic [4:0] se = 5'b00101;
    vac_alarm_config vac_alarm_config_i (.mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .global_clear, .manual_spectrum_mode, .automatic_spectrum_mode,
        .manual_time_capture_mode, .root_sum_square, .active_rate, .bin_valid, .bin_index,
        .bin_mag, .record_end, .stat_valid, .z_statistic, .rss_statistic, .temperature,
        .supply, .diagnostic_flags, .first_alarm_pin, .second_alarm_pin);
    vac_host vac_host_i (.mclk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    initial begin
        forever #10 mclk = ~mclk;
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    function automatic logic [15:0] spec();
        return {10'h000, diagnostic_flags[13:8]};
    endfunction
    function automatic logic [15:0] pins();
        return {14'h0000, second_alarm_pin, first_alarm_pin};
    endfunction
    // Out-of-band bins carry full-scale magnitude, so a bound slip shows as a false flag
    task rec(input logic [15:0] xm, input logic [15:0] zm);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk);
            bin_valid <= 1'b1;
            bin_index <= 12'(15 + 17 * i);
            bin_mag <= (i == 1) ? {zm, 16'h0000, xm} : {3{16'hffff}};
        end
        @(posedge mclk);
        bin_valid <= 1'b0;
        record_end <= 1'b1;
        @(posedge mclk);
        record_end <= 1'b0;
        tick(4);
    endtask
    task pulse(input logic stat);
        @(posedge mclk);
        stat_valid <= stat;
        global_clear <= !stat;
        @(posedge mclk);
        stat_valid <= 1'b0;
        global_clear <= 1'b0;
        tick(4);
    endtask
    task finish_test;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_fail++;
        finish_test();
    end
    initial begin
        tick(4);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            vac_host_i.rd(ra[i], v);
            chk(v, rv[i]);
        end
        chk(pins(), 16'h0000);
        $display("test reset done");
        for (int r = 0; r < 4; r++) begin
            vac_host_i.wr(`VAC_OFS_SELECTOR, {6'h3f, 2'(r), 5'h1f, 3'd6});
            vac_host_i.wr(`VAC_OFS_Z_L2, 16'h1000 + 16'(r));
            vac_host_i.wr(`VAC_OFS_BAND_LOW, 16'hf100 + 16'(r));
        end
        for (int r = 0; r < 4; r++) begin
            vac_host_i.wr(`VAC_OFS_SELECTOR, {8'h00 | 8'(r), 8'h06});
            vac_host_i.rd(`VAC_OFS_Z_L2, v);
            chk(v, 16'h1000 + 16'(r));
            vac_host_i.rd(`VAC_OFS_BAND_LOW, v);
            chk(v & 16'h0fff, 16'h0100 + 16'(r));
        end
        $display("test store done");
        vac_host_i.wr(`VAC_OFS_SELECTOR, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            vac_host_i.wr(7'(32 + 2 * i), cv[i]);
        end
        vac_host_i.wr(`VAC_OFS_ALARM_CFG, 16'h02c5);
        @(posedge mclk);
        automatic_spectrum_mode <= 1'b1;
        rec(16'h0100, 16'h0300);
        rec(16'h0000, 16'h0000);
        rec(16'h0100, 16'h0300);
        chk(spec(), 16'h0000);
        rec(16'h0100, 16'h0300);
        chk(spec(), 16'h0025);
        chk(pins(), 16'h0003);
        vac_host_i.wr(`VAC_OFS_PIN_POL, 16'h0078);
        tick(3);
        chk(pins(), 16'h0000);
        rec(16'h0000, 16'h0000);
        chk(spec(), 16'h0025);
        vac_host_i.rd(`VAC_OFS_DIAG, v);
        chk(16'(v[13:8]), 16'h0025);
        vac_host_i.rd(`VAC_OFS_DIAG, v);
        chk(16'(v[13:8]), 16'h0000);
        tick(2);
        chk(pins(), 16'h0003);
        vac_host_i.wr(`VAC_OFS_ALARM_CFG, 16'h12c5);
        @(posedge mclk);
        automatic_spectrum_mode <= 1'b0;
        manual_spectrum_mode <= 1'b1;
        rec(16'h0100, 16'h0300);
        rec(16'h0100, 16'h0300);
        rec(16'h0000, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            vac_host_i.rd(`VAC_OFS_DIAG, v);
            chk(16'(v[13:8]), 16'h0025);
        end
        pulse(1'b0);
        chk(spec(), 16'h0000);
        $display("test spectral done");
        vac_host_i.wr(`VAC_OFS_ALARM_CFG, 16'h0084);
        @(posedge mclk);
        manual_spectrum_mode <= 1'b0;
        manual_time_capture_mode <= 1'b1;
        root_sum_square <= 1'b1;
        pulse(1'b1);
        chk(16'(diagnostic_flags[13]), 16'h0001);
        // The capture result is a level, so clear only after the new statistic
        root_sum_square <= 1'b0;
        pulse(1'b1);
        pulse(1'b0);
        chk(16'(diagnostic_flags[13]), 16'h0000);
        $display("test capture done");
        manual_time_capture_mode <= 1'b0;
        vac_host_i.wr(`VAC_OFS_SYS_LIMIT, 16'h1000);
        for (int i = 0; i < 5; i++) begin
            vac_host_i.wr(`VAC_OFS_ALARM_CFG, sc[i]);
            tick(4);
            chk(16'(diagnostic_flags[14]), 16'(se[i]));
        end
        $display("test system done");
        finish_test();
    end
endmodule
bind vac_alarm_config vac_alarm_config_asserts vac_alarm_config_asserts_i (.mclk, .rst_n,
    .reg_wr, .reg_rd, .reg_addr, .global_clear, .record_end, .temperature, .supply, .reg_rdata,
    .diagnostic_flags, .first_alarm_pin, .second_alarm_pin);
`default_nettype wire

//--- sim/vac_host.sv
// Host model driving register strobes as the serial port would
`timescale 1ns/100ps
`default_nettype none
module vac_host (
    input wire logic mclk,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h7f;
        reg_wdata = 16'h0000;
    end
    // An idle cycle always follows a strobe, so no write lands in the selector's load cycle
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge mclk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire
